// file: logic/ucr_channel.sv
// Asynchronous serial channel: register port, transmitter, receiver and flags.
// Assumes rxd is already synchronous to clk and idles high.
`timescale 1ns/1ps
module ucr_channel (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rdata,
    // Serial line
    output logic             txd,
    input  wire logic        rxd,
    // Interrupt request
    output logic             irq
);

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    logic [15:0] clk_ctl_r;
    logic [15:0] mode_r;
    logic [15:0] baud_r;
    logic        moden_r;
    logic [15:0] inte_r;
    logic [7:0]  tx_hold_r;
    logic        tbe_r;
    logic        tend_r;
    logic        fe_r;
    logic        pe_r;
    logic        oe_r;
    logic [15:0] rdata_r;
    logic        irq_r;
    logic [15:0] intf;
    logic        wr_clk, wr_mod, wr_br, wr_ctl, wr_txd, wr_intf, wr_inte;
    logic        rd_rxd;
    logic        soft_rst;
    logic        len8, pren, odd, stop2;

    ucr_rxq_if rxq ();

    assign wr_clk   = wr_en && (addr == ucr_pkg::UCR_CLK_OFS);
    assign wr_mod   = wr_en && (addr == ucr_pkg::UCR_MOD_OFS);
    assign wr_br    = wr_en && (addr == ucr_pkg::UCR_BR_OFS);
    assign wr_ctl   = wr_en && (addr == ucr_pkg::UCR_CTL_OFS);
    assign wr_txd   = wr_en && (addr == ucr_pkg::UCR_TXD_OFS);
    assign wr_intf  = wr_en && (addr == ucr_pkg::UCR_INTF_OFS);
    assign wr_inte  = wr_en && (addr == ucr_pkg::UCR_INTE_OFS);
    assign rd_rxd   = rd_en && (addr == ucr_pkg::UCR_RXD_OFS);
    // The soft reset bit acts for one cycle and never reads back as one.
    assign soft_rst = wr_ctl && wdata[ucr_pkg::UCR_CTL_SFTRST];

    assign len8  = mode_r[ucr_pkg::UCR_MOD_CHLN];
    assign pren  = mode_r[ucr_pkg::UCR_MOD_PREN];
    assign odd   = mode_r[ucr_pkg::UCR_MOD_PRMD];
    assign stop2 = mode_r[ucr_pkg::UCR_MOD_STPB];

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_ctl_r <= ucr_pkg::UCR_CLK_RST;
            mode_r    <= ucr_pkg::UCR_MOD_RST;
            baud_r    <= ucr_pkg::UCR_BR_RST;
            inte_r    <= ucr_pkg::UCR_INTE_RST;
            moden_r   <= 1'b0;
        end else begin
            if (wr_clk) begin
                clk_ctl_r <= wdata & ucr_pkg::UCR_CLK_MASK;
            end
            if (wr_mod) begin
                mode_r <= wdata & ucr_pkg::UCR_MOD_MASK;
            end
            if (wr_br) begin
                baud_r <= wdata & ucr_pkg::UCR_BR_MASK;
            end
            if (wr_inte) begin
                inte_r <= wdata & ucr_pkg::UCR_INTE_MASK;
            end
            if (wr_ctl) begin
                moden_r <= wdata[ucr_pkg::UCR_CTL_MODEN];
            end
        end
    end

    // ------------------------------------------------------------------
    // Baud tick: one pulse every BRT+1 clocks, sixteen per bit
    // ------------------------------------------------------------------
    logic [7:0] baud_cnt_r;
    logic       tick;

    assign tick = moden_r && (baud_cnt_r == baud_r[ucr_pkg::UCR_BR_BRT_LO +: 8]);

    always_ff @(posedge clk) begin
        if (rst || soft_rst || !moden_r || tick) begin
            baud_cnt_r <= 8'h00;
        end else begin
            baud_cnt_r <= baud_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    ucr_pkg::ucr_state_e tx_state_r;
    logic [3:0] tx_os_r;
    logic [3:0] tx_bit_r;
    logic [7:0] tx_shift_r;
    logic       tx_par_r;
    logic       tx_out_r;
    logic       tx_load;
    logic       tx_os_end;
    logic       tx_done;
    logic [7:0] tx_word;

    assign tx_word   = len8 ? tx_hold_r : {1'b0, tx_hold_r[6:0]};
    assign tx_os_end = tick && (tx_os_r == ucr_pkg::UCR_OS_LAST);
    assign tx_load   = tick && !soft_rst && (tx_state_r == ucr_pkg::UCR_IDLE) && !tbe_r;
    assign tx_done   = tx_os_end && !soft_rst && (tx_state_r == ucr_pkg::UCR_STOP)
                       && (!stop2 || (tx_bit_r != 4'h0));

    always_ff @(posedge clk) begin
        if (wr_txd) begin
            tx_hold_r <= wdata[7:0];
        end else if (rst) begin
            tx_hold_r <= ucr_pkg::UCR_TXD_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst || !moden_r) begin
            tx_state_r <= ucr_pkg::UCR_IDLE;
            tx_os_r    <= 4'h0;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= 8'h00;
            tx_par_r   <= 1'b0;
            tx_out_r   <= 1'b1;
        end else if (tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            unique case (tx_state_r)
                ucr_pkg::UCR_IDLE: begin
                    tx_os_r <= 4'h0;
                    if (tx_load) begin
                        tx_shift_r <= tx_word;
                        tx_par_r   <= ucr_pkg::ucr_parity(tx_word, odd);
                        tx_out_r   <= 1'b0;
                        tx_state_r <= ucr_pkg::UCR_START;
                    end
                end
                ucr_pkg::UCR_START: begin
                    if (tx_os_end) begin
                        tx_bit_r   <= 4'h0;
                        tx_out_r   <= tx_shift_r[0];
                        tx_state_r <= ucr_pkg::UCR_DATA;
                    end
                end
                ucr_pkg::UCR_DATA: begin
                    if (tx_os_end) begin
                        if (tx_bit_r == ucr_pkg::ucr_last_bit(len8)) begin
                            tx_bit_r   <= 4'h0;
                            tx_out_r   <= pren ? tx_par_r : 1'b1;
                            tx_state_r <= pren ? ucr_pkg::UCR_PARITY : ucr_pkg::UCR_STOP;
                        end else begin
                            tx_bit_r   <= tx_bit_r + 4'h1;
                            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                            tx_out_r   <= tx_shift_r[1];
                        end
                    end
                end
                ucr_pkg::UCR_PARITY: begin
                    if (tx_os_end) begin
                        tx_out_r   <= 1'b1;
                        tx_state_r <= ucr_pkg::UCR_STOP;
                    end
                end
                ucr_pkg::UCR_STOP: begin
                    if (tx_done) begin
                        tx_bit_r   <= 4'h0;
                        tx_state_r <= ucr_pkg::UCR_IDLE;
                    end else if (tx_os_end) begin
                        tx_bit_r <= 4'h1;
                    end
                end
                default: begin
                    tx_state_r <= ucr_pkg::UCR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    ucr_pkg::ucr_state_e rx_state_r;
    logic [3:0] rx_os_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_shift_r;
    logic       rx_pbit_r;
    logic       rx_done;
    logic       rx_os_end;
    logic [7:0] rx_word;

    assign rx_word   = len8 ? rx_shift_r : {1'b0, rx_shift_r[7:1]};
    assign rx_os_end = tick && (rx_os_r == ucr_pkg::UCR_OS_LAST);
    assign rx_done   = rx_os_end && !soft_rst && (rx_state_r == ucr_pkg::UCR_STOP);

    always_ff @(posedge clk) begin
        if (rst || soft_rst || !moden_r) begin
            rx_state_r <= ucr_pkg::UCR_IDLE;
            rx_os_r    <= 4'h0;
            rx_bit_r   <= 4'h0;
            rx_shift_r <= 8'h00;
            rx_pbit_r  <= 1'b0;
        end else if (tick) begin
            rx_os_r <= rx_os_r + 4'h1;
            unique case (rx_state_r)
                ucr_pkg::UCR_IDLE: begin
                    rx_os_r <= 4'h0;
                    if (!rxd) begin
                        rx_state_r <= ucr_pkg::UCR_START;
                    end
                end
                ucr_pkg::UCR_START: begin
                    // Re-check at mid start bit so a short glitch is not taken as a frame.
                    if (rx_os_r == ucr_pkg::UCR_OS_MID) begin
                        rx_os_r    <= 4'h0;
                        rx_bit_r   <= 4'h0;
                        rx_state_r <= rxd ? ucr_pkg::UCR_IDLE : ucr_pkg::UCR_DATA;
                    end
                end
                ucr_pkg::UCR_DATA: begin
                    if (rx_os_end) begin
                        rx_shift_r <= {rxd, rx_shift_r[7:1]};
                        rx_bit_r   <= rx_bit_r + 4'h1;
                        if (rx_bit_r == ucr_pkg::ucr_last_bit(len8)) begin
                            rx_state_r <= pren ? ucr_pkg::UCR_PARITY : ucr_pkg::UCR_STOP;
                        end
                    end
                end
                ucr_pkg::UCR_PARITY: begin
                    if (rx_os_end) begin
                        rx_pbit_r  <= rxd;
                        rx_state_r <= ucr_pkg::UCR_STOP;
                    end
                end
                ucr_pkg::UCR_STOP: begin
                    if (rx_os_end) begin
                        rx_state_r <= ucr_pkg::UCR_IDLE;
                    end
                end
                default: begin
                    rx_state_r <= ucr_pkg::UCR_IDLE;
                end
            endcase
        end
    end

    assign rxq.push      = rx_done;
    assign rxq.push_data = rx_word;
    assign rxq.pop       = rd_rxd;
    assign rxq.flush     = soft_rst;

    ucr_rx_queue ucr_rx_queue_i (
        .clk (clk),
        .rst (rst),
        .q   (rxq)
    );

    // ------------------------------------------------------------------
    // Status flags: hardware sets win over software clears, except TBE, where a transmit write wins over the load
    // ------------------------------------------------------------------
    logic overrun;
    logic fe_evt;
    logic pe_evt;

    assign overrun = rx_done && (rxq.count == ucr_pkg::UCR_Q_DEPTH) && !rd_rxd;
    assign fe_evt  = rx_done && !rxd;
    assign pe_evt  = rx_done && pren && (rx_pbit_r != ucr_pkg::ucr_parity(rx_word, odd));

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            tbe_r <= ucr_pkg::UCR_TBE_RST;
        end else if (wr_txd) begin
            // A write while the buffer is full refills it, so the clear must stand.
            tbe_r <= 1'b0;
        end else if (tx_load) begin
            tbe_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            tend_r <= 1'b0;
            oe_r   <= 1'b0;
            fe_r   <= 1'b0;
            pe_r   <= 1'b0;
        end else begin
            tend_r <= (tx_done && tbe_r) ||
                      (tend_r && !(wr_intf && wdata[ucr_pkg::UCR_F_TEND]));
            oe_r   <= overrun || (oe_r && !(wr_intf && wdata[ucr_pkg::UCR_F_OE]));
            fe_r   <= fe_evt ||
                      (fe_r && !rd_rxd && !(wr_intf && wdata[ucr_pkg::UCR_F_FE]));
            pe_r   <= pe_evt ||
                      (pe_r && !rd_rxd && !(wr_intf && wdata[ucr_pkg::UCR_F_PE]));
        end
    end

    always_comb begin
        intf                       = 16'h0000;
        intf[ucr_pkg::UCR_F_RBSY]  = rx_state_r != ucr_pkg::UCR_IDLE;
        intf[ucr_pkg::UCR_F_TBSY]  = tx_state_r != ucr_pkg::UCR_IDLE;
        intf[ucr_pkg::UCR_F_TEND]  = tend_r;
        intf[ucr_pkg::UCR_F_FE]    = fe_r;
        intf[ucr_pkg::UCR_F_PE]    = pe_r;
        intf[ucr_pkg::UCR_F_OE]    = oe_r;
        intf[ucr_pkg::UCR_F_RB2]   = rxq.count == ucr_pkg::UCR_Q_DEPTH;
        intf[ucr_pkg::UCR_F_RB1]   = rxq.count != 2'h0;
        intf[ucr_pkg::UCR_F_TBE]   = tbe_r;
    end

    // ------------------------------------------------------------------
    // Read data and interrupt request
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !rd_en) begin
            rdata_r <= 16'h0000;
        end else begin
            unique case (addr)
                ucr_pkg::UCR_CLK_OFS:  rdata_r <= clk_ctl_r;
                ucr_pkg::UCR_MOD_OFS:  rdata_r <= mode_r;
                ucr_pkg::UCR_BR_OFS:   rdata_r <= baud_r;
                ucr_pkg::UCR_CTL_OFS:  rdata_r <= {15'h0000, moden_r};
                ucr_pkg::UCR_TXD_OFS:  rdata_r <= {8'h00, tx_hold_r};
                ucr_pkg::UCR_RXD_OFS:  rdata_r <= {8'h00, rxq.head};
                ucr_pkg::UCR_INTF_OFS: rdata_r <= intf;
                ucr_pkg::UCR_INTE_OFS: rdata_r <= inte_r;
                default:               rdata_r <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(intf[6:0] & inte_r[6:0]);
        end
    end

    assign rdata = rdata_r;
    assign txd   = tx_out_r;
    assign irq   = irq_r;

endmodule : ucr_channel

// file: logic/ucr_rx_queue.sv
// Two-entry receive queue; the oldest byte always sits in a register.
// Pushes beyond depth are dropped here; the owner's overrun logic only flags them.
`timescale 1ns/1ps
module ucr_rx_queue (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Queue side
    ucr_rxq_if.queue   q
);
    logic [7:0] slot0_r;
    logic [7:0] slot1_r;
    logic [1:0] count_r;
    logic       push_ok;
    logic       pop_ok;

    assign pop_ok  = q.pop && (count_r != 2'h0);
    assign push_ok = q.push && ((count_r != ucr_pkg::UCR_Q_DEPTH) || pop_ok);
    assign q.head  = slot0_r;
    assign q.count = count_r;

    always_ff @(posedge clk) begin
        if (rst || q.flush) begin
            slot0_r <= 8'h00;
            slot1_r <= 8'h00;
        end else if (pop_ok) begin
            if (count_r == ucr_pkg::UCR_Q_DEPTH) begin
                slot0_r <= slot1_r;
                if (push_ok) begin
                    slot1_r <= q.push_data;
                end
            end else if (push_ok) begin
                slot0_r <= q.push_data;
            end
        end else if (push_ok) begin
            if (count_r == 2'h0) begin
                slot0_r <= q.push_data;
            end else begin
                slot1_r <= q.push_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || q.flush) begin
            count_r <= 2'h0;
        end else begin
            count_r <= count_r + {1'b0, push_ok} - {1'b0, pop_ok};
        end
    end

endmodule : ucr_rx_queue

// file: shared/ucr_pkg.sv
// Constants, field positions, state types and shared helpers of the serial channel.
// Assumes a 16-bit register port addressed by the printed offsets.
package ucr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] UCR_CLK_OFS  = 16'h4380;
    localparam logic [15:0] UCR_MOD_OFS  = 16'h4382;
    localparam logic [15:0] UCR_BR_OFS   = 16'h4384;
    localparam logic [15:0] UCR_CTL_OFS  = 16'h4386;
    localparam logic [15:0] UCR_TXD_OFS  = 16'h4388;
    localparam logic [15:0] UCR_RXD_OFS  = 16'h438a;
    localparam logic [15:0] UCR_INTF_OFS = 16'h438c;
    localparam logic [15:0] UCR_INTE_OFS = 16'h438e;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] UCR_CLK_MASK  = 16'h0133;
    localparam logic [15:0] UCR_MOD_MASK  = 16'h037f;
    localparam logic [15:0] UCR_BR_MASK   = 16'h0fff;
    localparam logic [15:0] UCR_INTE_MASK = 16'h007f;
    localparam logic [15:0] UCR_CLK_RST   = 16'h0000;
    localparam logic [15:0] UCR_MOD_RST   = 16'h0000;
    localparam logic [15:0] UCR_BR_RST    = 16'h0000;
    localparam logic [15:0] UCR_INTE_RST  = 16'h0000;
    localparam logic [7:0]  UCR_TXD_RST   = 8'h00;
    localparam logic        UCR_TBE_RST   = 1'b1;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UCR_MOD_CHLN   = 3;
    localparam int UCR_MOD_PREN   = 2;
    localparam int UCR_MOD_PRMD   = 1;
    localparam int UCR_MOD_STPB   = 0;
    localparam int UCR_BR_BRT_LO  = 0;
    localparam int UCR_CTL_SFTRST = 1;
    localparam int UCR_CTL_MODEN  = 0;
    localparam int UCR_F_RBSY     = 9;
    localparam int UCR_F_TBSY     = 8;
    localparam int UCR_F_TEND     = 6;
    localparam int UCR_F_FE       = 5;
    localparam int UCR_F_PE       = 4;
    localparam int UCR_F_OE       = 3;
    localparam int UCR_F_RB2      = 2;
    localparam int UCR_F_RB1      = 1;
    localparam int UCR_F_TBE      = 0;

    // ------------------------------------------------------------------
    // Timing: sixteen baud ticks per bit
    // ------------------------------------------------------------------
    localparam logic [3:0] UCR_OS_LAST = 4'hf;
    localparam logic [3:0] UCR_OS_MID  = 4'h7;
    localparam logic [1:0] UCR_Q_DEPTH = 2'h2;

    typedef enum logic [4:0] {
        UCR_IDLE   = 5'b0_0001,
        UCR_START  = 5'b0_0010,
        UCR_DATA   = 5'b0_0100,
        UCR_PARITY = 5'b0_1000,
        UCR_STOP   = 5'b1_0000
    } ucr_state_e;

    // Parity bit to send or expect; unused upper data bits must be zero.
    function automatic logic ucr_parity(input logic [7:0] d, input logic odd);
        ucr_parity = (^d) ^ odd;
    endfunction : ucr_parity

    function automatic logic [3:0] ucr_last_bit(input logic len8);
        ucr_last_bit = len8 ? 4'h7 : 4'h6;
    endfunction : ucr_last_bit

endpackage : ucr_pkg

// file: shared/ucr_rxq_if.sv
// Carrier between the channel core and its two-byte receive queue.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface ucr_rxq_if;
    logic       push;
    logic [7:0] push_data;
    logic       pop;
    logic       flush;
    logic [7:0] head;
    logic [1:0] count;

    modport owner (output push, push_data, pop, flush, input head, count);
    modport queue (input push, push_data, pop, flush, output head, count);
endinterface : ucr_rxq_if

// file: tb/ucr_channel_assertions.sv
// Checker for the serial channel: register answers, status flags and interrupt request.
// Assumes it is bound to ucr_channel and sees only its ports.
`timescale 1ns/1ps
module ucr_channel_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rdata,
    // Serial line and interrupt
    input wire logic        txd,
    input wire logic        rxd,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       rdf_r;
    logic       fresh_r;
    logic       moden_r;
    logic       tbe_lo_r;
    logic [6:0] must_r;
    logic [6:0] inte_r;
    logic [6:0] clr;
    // --------------------------------
    // Flags that software has seen set must stay set until a clearing access.
    // --------------------------------
    always_comb begin
        clr = 7'h00;
        if (wr_en && addr == 16'h438c) clr = wdata[6:0] & 7'h78;
        if (rd_en && addr == 16'h438a) clr = 7'h36;
        if (wr_en && addr == 16'h4388) clr = 7'h01;
        if (wr_en && addr == 16'h4386 && wdata[1]) clr = 7'h7f;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdf_r  <= 1'b0;
            must_r <= 7'h00;
        end else begin
            rdf_r  <= rd_en && addr == 16'h438c;
            must_r <= (rdf_r ? rdata[6:0] : must_r) & ~clr;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            fresh_r  <= 1'b1;
            moden_r  <= 1'b0;
            tbe_lo_r <= 1'b0;
            inte_r   <= 7'h00;
        end else begin
            if (wr_en && addr == 16'h4388) fresh_r <= 1'b0;
            if (wr_en && addr == 16'h4386) {moden_r, tbe_lo_r} <= {wdata[0], 1'b0};
            if (wr_en && addr == 16'h4388 && !moden_r) tbe_lo_r <= 1'b1;
            if (wr_en && addr == 16'h438e) inte_r <= wdata[6:0];
        end
    end
    tbe_reset_a: assert property (rd_en && addr == 16'h438c && fresh_r |=> rdata[0])
        else $error("buffer empty flag low before any transmit write");
    tbe_clear_a: assert property (rd_en && addr == 16'h438c && tbe_lo_r |=> !rdata[0])
        else $error("buffer empty flag not cleared by transmit write");
    flags_hold_a: assert property (rdf_r |-> (rdata[6:0] & must_r) == must_r)
        else $error("status flag dropped without a clearing access");
    rx_upper_a: assert property (rd_en && addr == 16'h438a |=> rdata[15:8] == 8'h00)
        else $error("receive data upper byte not zero");
    flag_spare_a: assert property (rd_en && addr == 16'h438c |=> rdata[15:10] == 6'h00 && !rdata[7])
        else $error("unused status bits not zero");
    irq_enable_a: assert property (irq |-> $past(inte_r) != 7'h00)
        else $error("interrupt raised with all enables off");
    irq_off_a: assert property (wr_en && addr == 16'h438e && wdata[6:0] == 7'h00 |=> ##1 !irq)
        else $error("interrupt still raised after enables cleared");
    cover property ($rose(irq));
    cover property (rdf_r && rdata[3]);
    cover property (rdf_r && rdata[5] && rdata[4]);
endmodule : ucr_channel_assertions

bind ucr_channel ucr_channel_assertions ucr_channel_assertions_i (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .txd(txd), .rxd(rxd), .irq(irq));

// file: tb/ucr_channel_tb.sv
// Bench for the serial channel: register table, status flags and interrupt request.
// Assumes the channel, its checker and the remote model are compiled first.
`timescale 1ns/1ps
module ucr_channel_tb;
    typedef struct packed {
        logic        w;
        logic [15:0] a;
        logic [15:0] d;
    } ucr_row_s;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [15:0] addr  = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] rdata;
    logic        txd;
    logic        rxd;
    logic        irq;
    logic [7:0]  heard;
    int          fails = 0;
    int          check_count = 0;
    // A read row holds the expected word in its data field.
    ucr_row_s    rows [28] = '{
        '{1'b0, 16'h4380, 16'h0000}, '{1'b0, 16'h4382, 16'h0000}, '{1'b0, 16'h4384, 16'h0000},
        '{1'b0, 16'h4386, 16'h0000}, '{1'b0, 16'h4388, 16'h0000}, '{1'b0, 16'h438a, 16'h0000},
        '{1'b0, 16'h438c, 16'h0001}, '{1'b0, 16'h438e, 16'h0000}, '{1'b0, 16'h4390, 16'h0000},
        '{1'b1, 16'h4390, 16'hffff}, '{1'b1, 16'h4380, 16'hffff}, '{1'b0, 16'h4380, 16'h0133},
        '{1'b1, 16'h4382, 16'hffff}, '{1'b0, 16'h4382, 16'h037f}, '{1'b1, 16'h4384, 16'hffff},
        '{1'b0, 16'h4384, 16'h0fff}, '{1'b1, 16'h438e, 16'hffff}, '{1'b0, 16'h438e, 16'h007f},
        '{1'b1, 16'h438a, 16'hffff}, '{1'b0, 16'h438a, 16'h0000}, '{1'b1, 16'h438c, 16'hffff},
        '{1'b0, 16'h438c, 16'h0001}, '{1'b1, 16'h438e, 16'h0001}, '{1'b1, 16'h4382, 16'h0001},
        '{1'b1, 16'h4384, 16'h0000}, '{1'b1, 16'h4388, 16'h0025}, '{1'b0, 16'h4388, 16'h0025},
        '{1'b0, 16'h438c, 16'h0000}};

    always #20 clk = ~clk;

    ucr_channel ucr_channel_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .txd(txd), .rxd(rxd), .irq(irq));
    ucr_remote_model ucr_remote_model_i (.clk(clk), .txd(txd), .rxd(rxd), .heard(heard));

    // --------------------------------
    // Bus access and comparison
    // --------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd
    task automatic rc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rc
    task automatic results();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // Waits for the frame-finished flag; giving up counts as a mismatch.
    task automatic wait_end();
        logic [15:0] v;
        for (int n = 0; n < 400; n++) begin
            rd(16'h438c, v);
            if (v[6] === 1'b1) return;
        end
        fails++;
        results();
    endtask : wait_end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rc(rows[i].a, rows[i].d);
            end
        end
        chk({15'h0000, irq}, 16'h0000);
        $display("test register table done");
        wr(16'h4386, 16'h0001);
        for (int n = 0; n < 20 && irq !== 1'b1; n++) @(negedge clk);
        chk({15'h0000, irq}, 16'h0001);
        wait_end();
        chk({8'h00, heard}, 16'h00a5);
        wr(16'h438c, 16'h0000);
        rc(16'h438c, 16'h0041);
        wr(16'h438c, 16'h0040);
        rc(16'h438c, 16'h0001);
        wr(16'h438e, 16'h0000);
        repeat (3) @(negedge clk);
        chk({15'h0000, irq}, 16'h0000);
        $display("test transmit done");
        wr(16'h4382, 16'h0008);
        ucr_remote_model_i.send(8'h3c, 1'b0, 1'b0, 1'b1);
        ucr_remote_model_i.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rc(16'h438c, 16'h0007);
        wr(16'h438c, 16'h0006);
        rc(16'h438c, 16'h0007);
        ucr_remote_model_i.send(8'h11, 1'b0, 1'b0, 1'b1);
        rc(16'h438c, 16'h000f);
        rc(16'h438a, 16'h003c);
        rc(16'h438c, 16'h000b);
        rc(16'h438a, 16'h005a);
        rc(16'h438c, 16'h0009);
        wr(16'h438c, 16'h0008);
        rc(16'h438c, 16'h0001);
        $display("test receive and overrun done");
        wr(16'h4382, 16'h000e);
        ucr_remote_model_i.send(8'h96, 1'b1, 1'b0, 1'b0);
        rc(16'h438c, 16'h0033);
        wr(16'h438c, 16'h0010);
        rc(16'h438c, 16'h0023);
        rc(16'h438a, 16'h0096);
        rc(16'h438c, 16'h0001);
        $display("test line errors done");
        wr(16'h4386, 16'h0003);
        rc(16'h4386, 16'h0001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc(16'h438c, 16'h0001);
        rc(16'h4386, 16'h0000);
        $display("test second reset done");
        results();
    end
endmodule : ucr_channel_tb

// file: tb/ucr_remote_model.sv
// Remote serial device: frames bytes onto the line and collects bytes heard from the channel.
// Assumes sixteen clocks per bit, so the channel runs with a divisor of zero.
`timescale 1ns/1ps
module ucr_remote_model #(
    parameter int BIT_CLKS = 16
) (
    // Clock
    input wire logic       clk,
    // Serial line
    input wire logic       txd,
    output logic           rxd,
    // Last byte heard
    output logic     [7:0] heard
);
    initial rxd = 1'b1;
    // --------------------------------
    // Sender: even parity, either parity or stop may be spoiled on request.
    // --------------------------------
    task automatic send(input logic [7:0] d, input logic par_en, input logic par_bad, input logic stop);
        logic [10:0] f;
        f = {stop, (^d) ^ par_bad, d, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || par_en) begin
                rxd <= f[i];
                repeat (BIT_CLKS) @(posedge clk);
            end
        end
        rxd <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge clk);
    endtask : send
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            heard[i] <= txd;
        end
    end
endmodule : ucr_remote_model
